// ==== usf_pkg.sv ====
// Constants shared by the serial status flag block
package usf_pkg;
    // ------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 9;
    localparam int CTRL_W = 4;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] CONTROL_OFF = 8'h08;
    localparam logic [7:0] DATA_OFF = 8'h0c;
    // ------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------
    localparam int TXE_BIT = 7;
    localparam int TC_BIT = 6;
    localparam int RXF_BIT = 5;
    localparam int IDLE_BIT = 4;
    localparam int OVR_BIT = 3;
    localparam int NOISE_BIT = 2;
    localparam int FE_BIT = 1;
    localparam int PAR_BIT = 0;
    localparam logic [7:0] RX_FLAGS = 8'h3f;
    localparam logic [7:0] TX_FLAGS = 8'hc0;
    // ------------------------------------------------------------
    // Control bit positions
    // ------------------------------------------------------------
    localparam int LEN_BIT = 0;
    localparam int PCE_BIT = 1;
    localparam int PTS_BIT = 2;
    localparam int RWU_BIT = 3;
    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_RST = 8'hc0;
    localparam logic [CTRL_W-1:0] CONTROL_RST = 4'h0;
    localparam logic [3:0] IDLE_ONES_8 = 4'ha;
    localparam logic [3:0] IDLE_ONES_9 = 4'hb;
    localparam logic [3:0] COUNT_ONE = 4'h1;
    localparam logic [3:0] COUNT_ZERO = 4'h0;
endpackage

// ==== usf_top.sv ====
// Serial status flag logic with its APB register slave
//
// Operation
// R1 - Status read then data access clears flags
// R2 - Status register writes change nothing
// R3 - Shift register load sets transmit empty
// R4 - Armed data write clears transmit empty
// R5 - Complete flag low while anything sends
// R6 - Line idles high while complete set
// R7 - Queueing or armed write clears complete; the code clears it on any data write
// R8 - Frame to data register sets full
// R9 - Ten or eleven ones set idle
// R10 - Idle rearmed only by new frame
// R11 - Standby blocks idle flag setting
// R12 - Armed data read clears idle
// R13 - Second unread frame sets overrun
// R14 - Overrun frame discarded, data kept
// R15 - Armed data read clears overrun
// R16 - Noise set with full, not overrun
// R17 - Stop zero sets framing error
// R18 - Framing error blocks further reception
// R19 - Parity mismatch sets parity error
// R20 - Armed data read clears error flags
// R21 - Length bit selects nine or eight
// R22 - Wakeup bit is standby, hardware clears
// R23 - Only flags seen by read clear; the code also clears complete on any data write
`timescale 1ns/1ps
module usf_top (
    // Clock, reset and freeze
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [usf_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmitter core
    input wire logic tx_load,
    input wire logic tx_busy,
    input wire logic tx_queue,
    input wire logic tx_serial,
    output logic [usf_pkg::DATA_W-1:0] tx_data,
    output logic tx_empty,
    output logic txd,
    // Receiver core
    input wire logic rxd,
    input wire logic rx_bit_tick,
    input wire logic rx_frame_done,
    input wire logic [usf_pkg::DATA_W-1:0] rx_frame_data,
    input wire logic rx_parity_bit,
    input wire logic rx_noise,
    input wire logic rx_stop_zero,
    input wire logic rx_wakeup,
    // Receiver configuration
    output logic rx_blocked,
    output logic rx_standby,
    output logic nine_bit_mode,
    output logic parity_check_enable,
    output logic parity_type_select
);
    import usf_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0] flags; // Status flags
    logic [7:0] next_flags; // Next status flags
    logic [7:0] snap; // Flags returned by last status read
    logic [CTRL_W-1:0] ctrl; // Control bits
    logic [DATA_W-1:0] rx_data; // Receive data register
    logic rxd_meta; // Sync stage one
    logic rxd_sync; // Sync stage two
    logic [3:0] ones_count; // Consecutive ones seen
    logic idle_armed; // Idle may be set
    logic apb_setup; // First access cycle
    logic apb_done; // Completing access cycle
    logic status_rd; // Status read completes
    logic data_rd; // Data read completes
    logic data_wr; // Data write completes
    logic ctrl_wr; // Control write completes
    logic frame_in; // Frame accepted for handling
    logic full_held; // Earlier frame still unread
    logic par_bad; // Received parity mismatch
    logic idle_hit; // Idle line reached this tick
    logic [3:0] idle_target; // Ones needed for idle

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Address match against one register
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // The slave inserts one wait state. The first access cycle raises
    // pready and the second one completes the transfer. Side effects of
    // a clear sequence happen only on the completing cycle, so an access
    // stretched by a low clock enable cannot clear a flag twice.
    // Bus phase decode
    assign apb_setup = psel && penable && !pready;
    assign apb_done = ce && psel && penable && pready;
    assign status_rd = apb_done && !pwrite && hit(paddr, STATUS_OFF);
    assign data_rd = apb_done && !pwrite && hit(paddr, DATA_OFF);
    assign data_wr = apb_done && pwrite && hit(paddr, DATA_OFF);
    assign ctrl_wr = apb_done && pwrite && hit(paddr, CONTROL_OFF); // [R2]

    // Frame handling terms
    // A frame is ignored whole while a framing error stands
    assign frame_in = rx_frame_done && !flags[FE_BIT]; // [R18]
    assign full_held = flags[RXF_BIT] && !(data_rd && snap[RXF_BIT]);
    assign par_bad = (ctrl[LEN_BIT] ? ^rx_frame_data : ^rx_frame_data[7:0])
        ^ rx_parity_bit ^ ctrl[PTS_BIT];
    assign idle_target = ctrl[LEN_BIT] ? IDLE_ONES_9 : IDLE_ONES_8; // [R21]
    assign idle_hit = rx_bit_tick && rxd_sync && (ones_count == idle_target - COUNT_ONE);

    // Configuration and transmit empty outputs straight from flops
    assign rx_blocked = flags[FE_BIT];
    assign rx_standby = ctrl[RWU_BIT];
    assign nine_bit_mode = ctrl[LEN_BIT];
    assign parity_check_enable = ctrl[PCE_BIT];
    assign parity_type_select = ctrl[PTS_BIT];
    assign tx_empty = flags[TXE_BIT];

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // Ready one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else if (ce) begin
            pready <= apb_setup;
        end
    end

    // Read data and error captured before ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (ce && apb_setup) begin
            pslverr <= !(hit(paddr, STATUS_OFF) || hit(paddr, CONTROL_OFF)
                || hit(paddr, DATA_OFF));
            if (pwrite) begin
                prdata <= 32'h0;
            end else if (hit(paddr, STATUS_OFF)) begin
                prdata <= {24'h0, flags};
            end else if (hit(paddr, CONTROL_OFF)) begin
                prdata <= {28'h0, ctrl};
            end else if (hit(paddr, DATA_OFF)) begin
                prdata <= {23'h0, rx_data};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Software writes, wakeup clears standby
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CONTROL_RST;
        end else if (ce) begin
            if (ctrl_wr) begin
                ctrl <= pwdata[CTRL_W-1:0];
            end else if (rx_wakeup) begin
                ctrl[RWU_BIT] <= 1'b0; // [R22]
            end
        end
    end

    // Transmit data register, loaded by data writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_data <= '0;
        end else if (ce && data_wr) begin
            tx_data <= pwdata[DATA_W-1:0];
        end
    end

    // Receive data register, kept on overrun
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data <= '0;
        end else if (ce && frame_in && !full_held) begin
            rx_data <= rx_frame_data; // [R14]
        end
    end

    // ------------------------------------------------------------
    // Clear sequence snapshot
    // ------------------------------------------------------------
    // Status read arms, data access disarms its group
    // The snapshot is what software actually saw, so a flag that rises
    // after the status read survives the following data access, except complete on a data write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snap <= 8'h0;
        end else if (ce) begin
            if (status_rd) begin
                snap <= prdata[7:0]; // [R1] [R23]
            end else if (data_rd) begin
                snap <= snap & ~RX_FLAGS;
            end else if (data_wr) begin
                snap <= snap & ~TX_FLAGS;
            end
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Clears first, then sets, so sets win, except complete where clear wins
    always_comb begin
        next_flags = flags;
        // Transmit empty
        if (data_wr && snap[TXE_BIT]) begin
            next_flags[TXE_BIT] = 1'b0; // [R4]
        end
        if (tx_load) begin
            next_flags[TXE_BIT] = 1'b1; // [R3]
        end
        // Complete: clear wins over set
        if (tx_busy || tx_queue || data_wr || (data_wr && snap[TC_BIT])) begin
            next_flags[TC_BIT] = 1'b0; // [R5] [R7]
        end else if (next_flags[TXE_BIT]) begin
            next_flags[TC_BIT] = 1'b1; // [R5]
        end
        // Receive group cleared by armed data read
        if (data_rd) begin
            next_flags = next_flags & ~(snap & RX_FLAGS); // [R12] [R15] [R20]
        end
        // Frame arrival
        if (frame_in) begin
            if (full_held) begin
                next_flags[OVR_BIT] = 1'b1; // [R13]
            end else begin
                next_flags[RXF_BIT] = 1'b1; // [R8]
                if (rx_noise) begin
                    next_flags[NOISE_BIT] = 1'b1; // [R16]
                end
                if (rx_stop_zero) begin
                    next_flags[FE_BIT] = 1'b1; // [R17]
                end
                if (ctrl[PCE_BIT] && par_bad) begin
                    next_flags[PAR_BIT] = 1'b1; // [R19]
                end
            end
        end
        // Idle line
        if (idle_hit && idle_armed && !ctrl[RWU_BIT]) begin
            next_flags[IDLE_BIT] = 1'b1; // [R9] [R11]
        end
    end

    // Flag register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= STATUS_RST;
        end else if (ce) begin
            flags <= next_flags;
        end
    end

    // ------------------------------------------------------------
    // Idle line detection
    // ------------------------------------------------------------
    // Two-flop sync of the receive pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
        end else if (ce) begin
            rxd_meta <= rxd;
            rxd_sync <= rxd_meta;
        end
    end

    // Count ones per bit tick, saturate at target
    // Saturation keeps a long idle line from setting the flag twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ones_count <= COUNT_ZERO;
        end else if (ce && rx_bit_tick) begin
            if (!rxd_sync) begin
                ones_count <= COUNT_ZERO;
            end else if (ones_count < idle_target) begin
                ones_count <= ones_count + COUNT_ONE; // [R9]
            end
        end
    end

    // Idle rearmed by a new frame, disarmed on clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_armed <= 1'b1;
        end else if (ce) begin
            if (frame_in && !full_held) begin
                idle_armed <= 1'b1; // [R10]
            end else if (flags[IDLE_BIT] && !next_flags[IDLE_BIT]) begin
                idle_armed <= 1'b0; // [R10]
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit line
    // ------------------------------------------------------------
    // Idle high while complete, else shifter bit
    // Registered so the pin never glitches between the two sources
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd <= 1'b1;
        end else if (ce) begin
            txd <= flags[TC_BIT] ? 1'b1 : tx_serial; // [R6]
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_status_write_void: assert property ( // [R2]
        apb_done && pwrite && hit(paddr, STATUS_OFF) |=> $stable(ctrl) && $stable(tx_data))
        else $error("status write changed state");
    chk_txe_on_load: assert property ( // [R3]
        ce && tx_load |=> flags[TXE_BIT])
        else $error("load did not set transmit empty");
    chk_txe_armed_clear: assert property ( // [R4]
        data_wr && snap[TXE_BIT] && !tx_load |=> !flags[TXE_BIT] && !snap[TXE_BIT])
        else $error("armed write did not clear transmit empty");
    chk_tc_busy_low: assert property ( // [R5]
        ce && tx_busy |=> !flags[TC_BIT])
        else $error("complete set while busy");
    chk_txd_idle_high: assert property ( // [R6]
        ce && flags[TC_BIT] |=> txd)
        else $error("line not idle while complete");
    chk_tc_queue_clear: assert property ( // [R7]
        ce && tx_queue |=> !flags[TC_BIT])
        else $error("queue did not clear complete");
    chk_rxf_frame_load: assert property ( // [R8]
        ce && frame_in && !full_held |=> flags[RXF_BIT] && rx_data == $past(rx_frame_data))
        else $error("frame not loaded");
    chk_overrun_keep: assert property ( // [R13]
        ce && frame_in && full_held |=> flags[OVR_BIT] && $stable(rx_data) && flags[RXF_BIT])
        else $error("overrun mishandled");
    chk_fe_blocks_rx: assert property ( // [R18]
        ce && flags[FE_BIT] |=> $stable(rx_data))
        else $error("data taken during framing error");
    chk_idle_standby: assert property ( // [R11]
        ce && ctrl[RWU_BIT] && !flags[IDLE_BIT] |=> !flags[IDLE_BIT])
        else $error("idle set in standby");
    chk_unseen_kept: assert property ( // [R23]
        data_rd && flags[NOISE_BIT] && !snap[NOISE_BIT] |=> flags[NOISE_BIT])
        else $error("unseen flag cleared");
    chk_tc_write_clear: assert property ( // [R7]
        data_wr |=> !flags[TC_BIT])
        else $error("data write left complete set");
    chk_idle_disarmed: assert property ( // [R10]
        ce && !idle_armed && !flags[IDLE_BIT] |=> !flags[IDLE_BIT])
        else $error("idle set while disarmed");
    chk_idle_armed_clear: assert property ( // [R12]
        data_rd && snap[IDLE_BIT] && !idle_hit |=> !flags[IDLE_BIT])
        else $error("armed read did not clear idle");
endmodule

// ==== usf_remote.sv ====
// Remote serial sender model driving the receive line and bit ticks
`timescale 1ns/1ps
module usf_remote (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Line control from the bench
    input wire logic line_idle,
    input wire logic [7:0] target,
    // Receiver side
    output logic rxd,
    output logic rx_bit_tick,
    output logic [7:0] ones
);
    logic [1:0] div; // Bit time divider
    // ----------------------------------------
    // Line, ticks and ones count
    // ----------------------------------------
    // Line moves only at bit boundaries; ticks stop once target ones sent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= 2'h0;
            rxd <= 1'b1;
            rx_bit_tick <= 1'b0;
            ones <= 8'h00;
        end else begin
            div <= div + 2'h1;
            // Line level changes away from the tick
            if (div == 2'h3) begin
                rxd <= line_idle;
            end
            rx_bit_tick <= (div == 2'h1) && (!rxd || ones < target);
            // Consecutive ones seen by the receiver
            if (rx_bit_tick) begin
                ones <= rxd ? ones + 8'h01 : 8'h00;
            end
        end
    end
endmodule

// ==== tb.sv ====
// Self-checking bench for the serial status flag block
`timescale 1ns/1ps
module tb;
    import usf_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, serr, tx_empty, txd, rxd, rx_bit_tick;
    logic tx_load = 1'b0, tx_busy = 1'b0, tx_queue = 1'b0, tx_serial = 1'b0;
    logic [DATA_W-1:0] tx_data, rx_frame_data = 9'h000;
    logic rx_frame_done = 1'b0, rx_parity_bit = 1'b0, rx_noise = 1'b0;
    logic rx_stop_zero = 1'b0, rx_wakeup = 1'b0, line_idle = 1'b0;
    logic rx_blocked, rx_standby, nine_bit_mode, parity_check_enable, parity_type_select;
    logic [7:0] target = 8'h00, ones;
    int n_errors = 0;
    int comparisons = 0;
    // Clock of 8 ns
    always #4 pclk = ~pclk;
    usf_top dut_u (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_load(tx_load),
        .tx_busy(tx_busy), .tx_queue(tx_queue), .tx_serial(tx_serial),
        .tx_data(tx_data), .tx_empty(tx_empty), .txd(txd), .rxd(rxd),
        .rx_bit_tick(rx_bit_tick), .rx_frame_done(rx_frame_done),
        .rx_frame_data(rx_frame_data), .rx_parity_bit(rx_parity_bit),
        .rx_noise(rx_noise), .rx_stop_zero(rx_stop_zero), .rx_wakeup(rx_wakeup),
        .rx_blocked(rx_blocked), .rx_standby(rx_standby), .nine_bit_mode(nine_bit_mode),
        .parity_check_enable(parity_check_enable), .parity_type_select(parity_type_select));
    usf_remote remote_u (.pclk(pclk), .presetn(presetn), .line_idle(line_idle),
        .target(target), .rxd(rxd), .rx_bit_tick(rx_bit_tick), .ones(ones));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // One APB transfer, waiting for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) n_errors++;
        rdv = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let outputs launched at the completing edge settle
        @(posedge pclk);
    endtask
    // Compare one value and count it
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Status read compared under a mask
    task automatic st(input logic [7:0] e, input logic [7:0] m);
        apb(1'b0, STATUS_OFF, 32'h0);
        chk("status", {24'h0, e & m}, rdv & {24'h0, m});
    endtask
    task automatic clr_rx();
        apb(1'b0, STATUS_OFF, 32'h0);
        apb(1'b0, DATA_OFF, 32'h0);
    endtask
    // Receiver frame event: f is stop zero, noise, parity bit
    task automatic frame(input logic [8:0] d, input logic [2:0] f);
        @(posedge pclk);
        rx_frame_done <= 1'b1;
        rx_frame_data <= d;
        {rx_stop_zero, rx_noise, rx_parity_bit} <= f;
        @(posedge pclk);
        rx_frame_done <= 1'b0;
        {rx_stop_zero, rx_noise, rx_parity_bit} <= 3'h0;
    endtask
    // Remote sends ones until t seen in a row
    task automatic run_ones(input logic [7:0] t);
        int n = 0;
        target <= t;
        while (ones !== t && n < 400) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 400) n_errors++;
        repeat (3) @(posedge pclk);
    endtask
    task automatic line_cycle();
        line_idle <= 1'b0;
        repeat (16) @(posedge pclk);
        line_idle <= 1'b1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        st(8'hc0, 8'hff);
        chk("txd", 32'h1, {31'h0, txd});
        apb(1'b1, STATUS_OFF, 32'h0000_00ff);
        chk("status write error", 32'h0, {31'h0, serr});
        st(8'hc0, 8'hff);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, serr});
        $display("test reset done");
    endtask
    task automatic t_tx();
        apb(1'b1, DATA_OFF, 32'h1a5);
        chk("tx data", 32'h1a5, {23'h0, tx_data});
        st(8'h00, TX_FLAGS);
        chk("tx empty clear", 32'h0, {31'h0, tx_empty});
        chk("txd shifter", 32'h0, {31'h0, txd});
        @(posedge pclk);
        tx_load <= 1'b1;
        tx_busy <= 1'b1;
        @(posedge pclk);
        tx_load <= 1'b0;
        st(8'h80, TX_FLAGS);
        chk("tx empty set", 32'h1, {31'h0, tx_empty});
        apb(1'b1, DATA_OFF, 32'h0f0);
        @(posedge pclk);
        tx_load <= 1'b1;
        @(posedge pclk);
        tx_load <= 1'b0;
        apb(1'b1, DATA_OFF, 32'h00f);
        st(8'h80, TX_FLAGS);
        tx_busy <= 1'b0;
        st(8'hc0, TX_FLAGS);
        chk("txd idle", 32'h1, {31'h0, txd});
        @(posedge pclk);
        tx_queue <= 1'b1;
        tx_busy <= 1'b1;
        @(posedge pclk);
        tx_queue <= 1'b0;
        st(8'h80, TX_FLAGS);
        tx_busy <= 1'b0;
        $display("test transmit done");
    endtask
    task automatic t_rx();
        frame(9'h05a, 3'h0);
        st(8'h20, RX_FLAGS);
        frame(9'h0c3, 3'h2);
        apb(1'b0, DATA_OFF, 32'h0);
        chk("rx data kept", 32'h05a, rdv);
        st(8'h08, RX_FLAGS);
        apb(1'b0, DATA_OFF, 32'h0);
        st(8'h00, RX_FLAGS);
        frame(9'h044, 3'h2);
        apb(1'b0, DATA_OFF, 32'h0);
        st(8'h24, RX_FLAGS);
        clr_rx();
        st(8'h00, RX_FLAGS);
        $display("test receive done");
    endtask
    task automatic t_err();
        apb(1'b1, CONTROL_OFF, 32'h2);
        frame(9'h001, 3'h6);
        st(8'h27, RX_FLAGS);
        chk("blocked", 32'h1, {31'h0, rx_blocked});
        frame(9'h0ff, 3'h0);
        st(8'h27, RX_FLAGS);
        apb(1'b0, DATA_OFF, 32'h0);
        chk("first frame", 32'h001, rdv);
        st(8'h00, RX_FLAGS);
        chk("unblocked", 32'h0, {31'h0, rx_blocked});
        apb(1'b1, CONTROL_OFF, 32'h6);
        chk("parity cfg", 32'h3, {30'h0, parity_check_enable, parity_type_select});
        apb(1'b0, CONTROL_OFF, 32'h0);
        chk("control", 32'h6, rdv);
        frame(9'h003, 3'h0);
        st(8'h21, RX_FLAGS);
        apb(1'b0, DATA_OFF, 32'h0);
        frame(9'h003, 3'h1);
        st(8'h20, RX_FLAGS);
        apb(1'b0, DATA_OFF, 32'h0);
        apb(1'b1, CONTROL_OFF, 32'h0);
        $display("test errors done");
    endtask
    task automatic t_idle();
        line_idle <= 1'b1;
        run_ones(8'd9);
        st(8'h00, 8'h10);
        run_ones(8'd10);
        st(8'h10, 8'h10);
        apb(1'b0, DATA_OFF, 32'h0);
        run_ones(8'd22);
        st(8'h00, 8'h10);
        frame(9'h011, 3'h0);
        line_cycle();
        run_ones(8'd10);
        st(8'h30, 8'h30);
        clr_rx();
        frame(9'h012, 3'h0);
        clr_rx();
        apb(1'b1, CONTROL_OFF, 32'h8);
        chk("standby", 32'h1, {31'h0, rx_standby});
        line_cycle();
        run_ones(8'd10);
        st(8'h00, 8'h10);
        @(posedge pclk);
        rx_wakeup <= 1'b1;
        @(posedge pclk);
        rx_wakeup <= 1'b0;
        @(posedge pclk);
        chk("standby cleared", 32'h0, {31'h0, rx_standby});
        apb(1'b1, CONTROL_OFF, 32'h1);
        chk("nine bit", 32'h1, {31'h0, nine_bit_mode});
        line_cycle();
        run_ones(8'd10);
        st(8'h00, 8'h10);
        run_ones(8'd11);
        st(8'h10, 8'h10);
        $display("test idle done");
    endtask
    // ----------------------------------------
    // Verdict, sequence and watchdog
    // ----------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tx();
        t_rx();
        t_err();
        t_idle();
        test_done();
    end
    initial begin
        #100us;
        n_errors++;
        test_done();
    end
endmodule
